//--- dv/pm_pin_peer.sv
// board pins and spi peer facing the pin mux
// assumes a pin follows the device when enabled, else the peer
`timescale 1ns/1ps
`default_nettype none

module pm_pin_peer
  import pm_pkg::*;
(
  // device pad drive
  input  wire pm_pad_type [2:0] a_pad,
  input  wire pm_pad_type [1:0] b_pad,
  // peer drive levels
  input  wire logic [2:0]       a_peer,
  input  wire logic [1:0]       b_peer,
  // resolved pin levels
  output var  logic [2:0]       a_pin,
  output var  logic [1:0]       b_pin
);
  // device drive wins, otherwise the peer level
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      a_pin[i] = a_pad[i].oe ? a_pad[i].dout : a_peer[i];
    end
    for (int i = 0; i < 2; i++) begin
      b_pin[i] = b_pad[i].oe ? b_pad[i].dout : b_peer[i];
    end
  end
endmodule

`default_nettype wire

//--- dv/pm_port_mux_chk.sv
// port checks of the pin mux
// assumes binding into pm_port_mux
`timescale 1ns/1ps
`default_nettype none

module pm_port_mux_chk
  import pm_pkg::*;
#(
  parameter int A_PINS = 3, // three-pin port width
  parameter int B_PINS = 2  // two-pin port width
) (
  // clock, reset, apb
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic [7:0]              paddr,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // configuration and spi
  input wire pm_clk_src_type          flash_clk_src,
  input wire logic                    flash_rtc_on_crystal,
  input wire logic                    spi_enable,
  input wire logic                    spi_master,
  input wire pm_spi_type              spi_to_pin,
  input wire logic                    osc_amp_out,
  // pads
  input wire pm_pad_type [A_PINS-1:0] port_a_pad,
  input wire logic [B_PINS-1:0]       port_b_in,
  input wire pm_pad_type [B_PINS-1:0] port_b_pad,
  input wire logic                    crystal_in_level
);
  logic xopt;    // crystal option claims the pins
  logic xin_own; // crystal input is no port pin
  logic mapped;  // address hits a register
  assign xopt = flash_clk_src == PM_SRC_CRYSTAL || flash_rtc_on_crystal;
  assign xin_own = xopt || flash_clk_src == PM_SRC_EXTERNAL;
  assign mapped = paddr[1:0] == 2'h0 && paddr <= PM_OFS_STATUS;

  ////////////////////////////////////////////////////////////////////////
  chk_one_wait: assert property (@(posedge clk) disable iff (!rst_n)
    psel && penable && !pready |=> pready) else $error("no wait answer");
  chk_ready_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    pready |=> !pready) else $error("pready too long");
  chk_err_map: assert property (@(posedge clk) disable iff (!rst_n)
    pready |-> pslverr == !mapped) else $error("bad pslverr");
  chk_reset_idle: assert property (@(posedge clk)
    !rst_n |-> port_a_pad == '0 && port_b_pad == '0)
    else $error("pads active in reset");
  chk_spi_master: assert property (
    @(posedge clk) disable iff (!rst_n)
    spi_enable && spi_master |=> port_a_pad[0].oe && port_a_pad[2].oe
    && !port_a_pad[1].oe && port_a_pad[0].dout == $past(spi_to_pin.mosi))
    else $error("master pin drive wrong");
  chk_spi_slave: assert property (
    @(posedge clk) disable iff (!rst_n)
    spi_enable && !spi_master |=> port_a_pad[1].oe && !port_a_pad[0].oe
    && !port_a_pad[2].oe && port_a_pad[1].dout == $past(spi_to_pin.miso))
    else $error("slave pin drive wrong");
  chk_xtal_drive: assert property (
    @(posedge clk) disable iff (!rst_n)
    xopt |=> port_b_pad[0].oe && port_b_pad[0].dout == $past(osc_amp_out))
    else $error("amplifier pin wrong");
  chk_xin_release: assert property (
    @(posedge clk) disable iff (!rst_n)
    xin_own |=> !port_b_pad[1].oe && !port_b_pad[1].pull_up)
    else $error("crystal pin driven");
  chk_xin_level: assert property (
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> crystal_in_level == $past(xin_own & port_b_in[1]))
    else $error("crystal level wrong");
endmodule

bind pm_port_mux pm_port_mux_chk #(.A_PINS(A_PINS), .B_PINS(B_PINS))
  pm_port_mux_chk_inst (.clk, .rst_n, .psel, .penable, .paddr, .pready,
  .pslverr, .flash_clk_src, .flash_rtc_on_crystal, .spi_enable,
  .spi_master, .spi_to_pin, .osc_amp_out, .port_a_pad, .port_b_in,
  .port_b_pad, .crystal_in_level);

`default_nettype wire

//--- dv/testbench.sv
// self-checking bench of the pin mux
// assumes the pin peer and the bound checker beside the design
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import pm_pkg::*;
  // reset starts unknown so that its first fall resets the design at once
  logic clk = 0, rst_n, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr, crystal_in_level, p;
  pm_clk_src_type flash_clk_src = PM_SRC_RC;
  logic flash_rtc_on_crystal = 0, spi_enable = 0, spi_master = 0;
  logic osc_amp_out = 0;
  pm_spi_type spi_to_pin = 0, spi_from_pin;
  logic [2:0] port_a_in, a_peer = 0;
  logic [1:0] port_b_in, b_peer = 0;
  pm_pad_type [2:0] port_a_pad;
  pm_pad_type [1:0] port_b_pad;
  int n_errors = 0, comparisons = 0;

  pm_port_mux pm_port_mux_inst (.clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .flash_clk_src,
    .flash_rtc_on_crystal, .spi_enable, .spi_master, .spi_to_pin,
    .spi_from_pin, .osc_amp_out, .port_a_in, .port_a_pad, .port_b_in,
    .port_b_pad, .crystal_in_level);
  pm_pin_peer pm_pin_peer_inst (.a_pad(port_a_pad), .b_pad(port_b_pad),
    .a_peer, .b_peer, .a_pin(port_a_in), .b_pin(port_b_in));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer: setup, access, held until pready stands at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // values read here are those that stand at this edge
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    check(q, x);
    check(32'(e), 32'(xe));
  endtask

  // let registered pad drive land, then look mid-cycle
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #50000;
    n_errors++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    check(32'(port_a_pad), 32'h0000_0000);
    check(32'(port_b_pad), 32'h0000_0000);
    rd(PM_OFS_A_MODE, 32'h0000_002A, 1'b0);
    rd(PM_OFS_A_LATCH, 32'h0000_0007, 1'b0);
    rd(PM_OFS_B_MODE, 32'h0000_000A, 1'b0);
    rd(PM_OFS_TRIM, 32'h0000_0000, 1'b0);
    rd(8'h18, 32'h0000_0000, 1'b1);
    $display("reset test done");
    // per-pin output types
    wr(PM_OFS_A_LATCH, 32'h0000_0002);
    wr(PM_OFS_A_MODE, 32'h0000_0031);
    wr(PM_OFS_B_LATCH, 32'h0000_0001);
    wr(PM_OFS_B_MODE, 32'h0000_000D);
    wr(PM_OFS_STATUS, 32'h0000_00FF);
    settle();
    check(32'(port_a_pad), 32'h0000_008A);
    check(32'(port_b_pad), 32'h0000_0016);
    rd(PM_OFS_STATUS, 32'h0000_0008, 1'b0);
    $display("mode test done");
    // spi master then slave
    @(posedge clk);
    spi_enable <= 1'b1;
    spi_master <= 1'b1;
    spi_to_pin <= 3'b101;
    a_peer     <= 3'b010;
    settle();
    check(32'(port_a_pad), 32'h0000_0186);
    check(32'(spi_from_pin), 32'h0000_0002);
    @(posedge clk);
    spi_master <= 1'b0;
    spi_to_pin <= 3'b010;
    a_peer     <= 3'b101;
    settle();
    check(32'(port_a_pad), 32'h0000_0030);
    check(32'(spi_from_pin), 32'h0000_0005);
    @(posedge clk);
    spi_enable <= 1'b0;
    settle();
    check(32'(port_a_pad), 32'h0000_008A);
    $display("spi test done");
    // clock output from rc, then external source
    wr(PM_OFS_TRIM, 32'h0000_0040);
    for (int s = 0; s < 2; s++) begin
      settle();
      for (int i = 0; i < 4; i++) begin
        p = port_b_pad[0].dout;
        @(negedge clk);
        check({30'h0, port_b_pad[0].oe, port_b_pad[0].dout},
              {31'h1, ~p});
      end
      @(posedge clk);
      flash_clk_src <= PM_SRC_EXTERNAL;
      b_peer        <= 2'b10;
    end
    settle();
    check({30'h0, port_b_pad[1].oe, port_b_pad[1].pull_up}, 32'h0);
    check(32'(crystal_in_level), 32'h0000_0001);
    // timer crystal takes the pins over the clock output
    @(posedge clk);
    flash_clk_src        <= PM_SRC_RC;
    flash_rtc_on_crystal <= 1'b1;
    settle();
    check({port_b_pad[0].oe, port_b_pad[0].dout}, 32'h2);
    @(posedge clk);
    osc_amp_out <= 1'b1;
    settle();
    check({port_b_pad[0].oe, port_b_pad[0].dout}, 32'h3);
    // crystal cpu source: amplifier pin and crystal input both claimed
    @(posedge clk);
    flash_rtc_on_crystal <= 1'b0;
    flash_clk_src        <= PM_SRC_CRYSTAL;
    osc_amp_out          <= 1'b0;
    settle();
    check(32'(port_b_pad), 32'h0000_0002);
    check(32'(crystal_in_level), 32'h0000_0001);
    rd(PM_OFS_STATUS, 32'h0000_00D0, 1'b0);
    // watchdog source frees both pins to the port
    @(posedge clk);
    flash_rtc_on_crystal <= 1'b0;
    flash_clk_src        <= PM_SRC_WATCHDOG;
    wr(PM_OFS_TRIM, 32'h0000_0000);
    settle();
    check(32'(port_b_pad), 32'h0000_0016);
    check(32'(crystal_in_level), 32'h0000_0000);
    $display("oscillator test done");
    // mid-run reset returns every latch to input-only
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    check(32'({port_a_pad, port_b_pad}), 32'h0000_0000);
    rd(PM_OFS_A_MODE, 32'h0000_002A, 1'b0);
    rd(PM_OFS_B_MODE, 32'h0000_000A, 1'b0);
    rd(PM_OFS_B_LATCH, 32'h0000_0003, 1'b0);
    $display("second reset test done");
    report_and_stop();
  end
endmodule

`default_nettype wire

//--- rtl/pm_pkg.sv
// constants, register map and carrier types of the port pin-function mux
// assumes a cpu clock of 200 MHz and a 32-bit apb register bus
package pm_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] PM_OFS_A_LATCH  = 8'h00; // three-pin port latch
  localparam logic [7:0] PM_OFS_A_MODE   = 8'h04; // three-pin output types
  localparam logic [7:0] PM_OFS_B_LATCH  = 8'h08; // two-pin port latch
  localparam logic [7:0] PM_OFS_B_MODE   = 8'h0C; // two-pin output types
  localparam logic [7:0] PM_OFS_TRIM     = 8'h10; // oscillator trim
  localparam logic [7:0] PM_OFS_STATUS   = 8'h14; // pin levels and owners

  ////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int         PM_TRIM_CLK_EN_BIT = 6;     // clock output enable
  localparam int         PM_MODE_W          = 2;     // bits per pin mode
  localparam logic [7:0] PM_TRIM_RESET      = 8'h00; // trim after reset
  localparam int         PM_ST_CLK_OUT_BIT  = 5;     // clock output active
  localparam int         PM_ST_XOUT_BIT     = 6;     // amplifier owns pin
  localparam int         PM_ST_XIN_BIT      = 7;     // crystal owns pin

  ////////////////////////////////////////////////////////////////////////
  // per-pin output types
  typedef enum logic [1:0] {
    PM_QUASI     = 2'h0,
    PM_PUSH_PULL = 2'h1,
    PM_INPUT     = 2'h2,
    PM_OPEN_DR   = 2'h3
  } pm_mode_type;

  // cpu clock source chosen by flash configuration
  typedef enum logic [1:0] {
    PM_SRC_RC       = 2'h0,
    PM_SRC_WATCHDOG = 2'h1,
    PM_SRC_EXTERNAL = 2'h2,
    PM_SRC_CRYSTAL  = 2'h3
  } pm_clk_src_type;

  // drive of one pad
  typedef struct packed {
    logic dout;    // level driven when enabled
    logic oe;      // output enable
    logic pull_up; // weak pull-up on
  } pm_pad_type;

  // spi core side signals, one bit per line
  typedef struct packed {
    logic mosi;
    logic miso;
    logic sclk;
  } pm_spi_type;

endpackage

//--- rtl/pm_port_mux.sv
// pin-function mux for the three-pin spi port and the two-pin
// oscillator / clock-output port, with an apb register slave
// assumes pad inputs already synchronous to clk, flash configuration
// static while running, and the spi core driving its own data lines
`timescale 1ns/1ps
`default_nettype none

module pm_port_mux
  import pm_pkg::*;
#(
  parameter int A_PINS = 3, // three-pin port width
  parameter int B_PINS = 2  // two-pin port width
) (
  // clock and reset
  input  wire  logic                 clk,
  input  wire  logic                 rst_n,
  // apb slave
  input  wire  logic                 psel,
  input  wire  logic                 penable,
  input  wire  logic                 pwrite,
  input  wire  logic [7:0]           paddr,
  input  wire  logic [31:0]          pwdata,
  output var   logic [31:0]          prdata,
  output var   logic                 pready,
  output var   logic                 pslverr,
  // flash configuration
  input  wire  pm_clk_src_type       flash_clk_src,
  input  wire  logic                 flash_rtc_on_crystal,
  // spi core
  input  wire  logic                 spi_enable,
  input  wire  logic                 spi_master,
  input  wire  pm_spi_type           spi_to_pin,
  output var   pm_spi_type           spi_from_pin,
  // oscillator amplifier output level
  input  wire  logic                 osc_amp_out,
  // three-pin port pads: bit 0 mosi, bit 1 miso, bit 2 serial clock
  input  wire  logic [A_PINS-1:0]    port_a_in,
  output var   pm_pad_type [A_PINS-1:0] port_a_pad,
  // two-pin port pads: bit 0 amplifier / clock out, bit 1 crystal in
  input  wire  logic [B_PINS-1:0]    port_b_in,
  output var   pm_pad_type [B_PINS-1:0] port_b_pad,
  // crystal input towards the oscillator
  output var   logic                 crystal_in_level
);

  ////////////////////////////////////////////////////////////////////////
  // pad drive from output type and latch bit
  function automatic pm_pad_type pm_drive(input logic [1:0] mode,
                                          input logic       latch);
    pm_pad_type pad;
    pad = '0;
    case (pm_mode_type'(mode))
      PM_QUASI: begin
        // strong low, weak pull-up for high
        pad.oe      = ~latch;
        pad.pull_up = 1'b1;
      end
      PM_PUSH_PULL: begin
        pad.oe   = 1'b1;
        pad.dout = latch;
      end
      PM_OPEN_DR: begin
        // only ever pulls low
        pad.oe = ~latch;
      end
      default: begin
        // input only: pad left alone
        pad = '0;
      end
    endcase
    return pad;
  endfunction

  // pad driven by a pin function
  function automatic pm_pad_type pm_func(input logic drive,
                                         input logic level);
    pm_pad_type pad;
    pad         = '0;
    pad.oe      = drive;
    pad.dout    = drive & level;
    return pad;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // software state
  logic [A_PINS-1:0]          a_latch;   // three-pin port latch
  logic [A_PINS*PM_MODE_W-1:0] a_mode;   // three-pin output types
  logic [B_PINS-1:0]          b_latch;   // two-pin port latch
  logic [B_PINS*PM_MODE_W-1:0] b_mode;   // two-pin output types
  logic [7:0]                 trim;      // oscillator trim register
  logic                       clk_div;   // halved cpu clock
  logic [A_PINS-1:0]          a_seen;    // sampled three-pin levels
  logic [B_PINS-1:0]          b_seen;    // sampled two-pin levels

  // pin ownership
  logic clk_out_allowed; // clock source permits clock output
  logic clk_out_active;  // clock output on the shared pin
  logic xout_owned;      // amplifier output owns the shared pin
  logic xin_owned;       // crystal input owns its pin

  ////////////////////////////////////////////////////////////////////////
  // ownership decode from flash configuration and trim
  always_comb begin
    // only rc, watchdog or external clock, crystal not on the rtc
    clk_out_allowed = (flash_clk_src != PM_SRC_CRYSTAL) &
                      ~flash_rtc_on_crystal;
    clk_out_active  = clk_out_allowed &
                      trim[PM_TRIM_CLK_EN_BIT];
    // amplifier needed for any crystal option
    xout_owned      = (flash_clk_src == PM_SRC_CRYSTAL) |
                      flash_rtc_on_crystal;
    // port use only for rc or watchdog with no rtc crystal
    xin_owned       = ~(((flash_clk_src == PM_SRC_RC) |
                         (flash_clk_src == PM_SRC_WATCHDOG)) &
                        ~flash_rtc_on_crystal);
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer on the second access cycle
  logic        bus_access;   // access phase this cycle
  logic        bus_commit;   // transfer completes at this edge
  logic        addr_ok;      // address is mapped
  logic [31:0] next_rdata;   // read data for the addressed register

  always_comb begin
    bus_access = psel & penable;
    bus_commit = bus_access & pready;
    addr_ok    = (paddr == PM_OFS_A_LATCH) | (paddr == PM_OFS_A_MODE) |
                 (paddr == PM_OFS_B_LATCH) | (paddr == PM_OFS_B_MODE) |
                 (paddr == PM_OFS_TRIM)    | (paddr == PM_OFS_STATUS);
  end

  // read mux, unmapped reads as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      PM_OFS_A_LATCH: next_rdata[A_PINS-1:0]           = a_latch;
      PM_OFS_A_MODE:  next_rdata[A_PINS*PM_MODE_W-1:0] = a_mode;
      PM_OFS_B_LATCH: next_rdata[B_PINS-1:0]           = b_latch;
      PM_OFS_B_MODE:  next_rdata[B_PINS*PM_MODE_W-1:0] = b_mode;
      PM_OFS_TRIM:    next_rdata[7:0]                  = trim;
      PM_OFS_STATUS: begin
        next_rdata[A_PINS-1:0]             = a_seen;
        next_rdata[A_PINS+B_PINS-1:A_PINS] = b_seen;
        next_rdata[PM_ST_CLK_OUT_BIT]      = clk_out_active;
        next_rdata[PM_ST_XOUT_BIT]         = xout_owned;
        next_rdata[PM_ST_XIN_BIT]          = xin_owned;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // handshake and read data flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      // ready rises one cycle into the access phase, for one cycle
      pready  <= bus_access & ~pready;
      pslverr <= bus_access & ~pready & ~addr_ok;
      if (bus_access & ~pready & ~pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes, taken only at the completing edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // every latch in input-only mode, pull-ups off
      a_latch <= '1;
      a_mode  <= {A_PINS{PM_INPUT}};
      b_latch <= '1;
      b_mode  <= {B_PINS{PM_INPUT}};
      trim    <= PM_TRIM_RESET;
    end else if (bus_commit & pwrite) begin
      case (paddr)
        PM_OFS_A_LATCH: a_latch <= pwdata[A_PINS-1:0];
        PM_OFS_A_MODE:  a_mode  <= pwdata[A_PINS*PM_MODE_W-1:0];
        PM_OFS_B_LATCH: b_latch <= pwdata[B_PINS-1:0];
        PM_OFS_B_MODE:  b_mode  <= pwdata[B_PINS*PM_MODE_W-1:0];
        PM_OFS_TRIM:    trim    <= pwdata[7:0];
        default: begin
          // unmapped write has no effect
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock output divider: toggles each cpu clock, so cpu clock / 2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_div <= 1'b0;
    end else if (clk_out_active) begin
      clk_div <= ~clk_div;
    end else begin
      clk_div <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next pad drive for both ports
  pm_pad_type [A_PINS-1:0] next_a_pad; // three-pin drive
  pm_pad_type [B_PINS-1:0] next_b_pad; // two-pin drive
  pm_spi_type              spi_drive;  // which spi lines drive out

  always_comb begin
    spi_drive.mosi = spi_master;
    spi_drive.miso = ~spi_master;
    spi_drive.sclk = spi_master;
  end

  genvar gi;
  generate
    // port latch drive for every three-pin pad
    for (gi = 0; gi < A_PINS; gi = gi + 1) begin : g_a
      pm_pad_type latch_pad;
      always_comb begin
        latch_pad = pm_drive(a_mode[gi*PM_MODE_W +: PM_MODE_W],
                             a_latch[gi]);
      end
    end
    // port latch drive for every two-pin pad
    for (gi = 0; gi < B_PINS; gi = gi + 1) begin : g_b
      pm_pad_type latch_pad;
      always_comb begin
        latch_pad = pm_drive(b_mode[gi*PM_MODE_W +: PM_MODE_W],
                             b_latch[gi]);
      end
    end
  endgenerate

  // spi functions take the three-pin pads while the spi is on
  always_comb begin
    next_a_pad = {g_a[2].latch_pad, g_a[1].latch_pad, g_a[0].latch_pad};
    if (spi_enable) begin
      next_a_pad[0] = pm_func(spi_drive.mosi, spi_to_pin.mosi);
      next_a_pad[1] = pm_func(spi_drive.miso, spi_to_pin.miso);
      next_a_pad[2] = pm_func(spi_drive.sclk, spi_to_pin.sclk);
    end
  end

  // oscillator and clock output take the two-pin pads first
  always_comb begin
    next_b_pad = {g_b[1].latch_pad, g_b[0].latch_pad};
    if (xout_owned) begin
      next_b_pad[0] = pm_func(1'b1, osc_amp_out);
    end else if (clk_out_active) begin
      next_b_pad[0] = pm_func(1'b1, ~clk_div);
    end
    if (xin_owned) begin
      // crystal or external clock input: pad released
      next_b_pad[1] = pm_func(1'b0, 1'b0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered pad drive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_pad <= '0;
      port_b_pad <= '0;
    end else begin
      port_a_pad <= next_a_pad;
      port_b_pad <= next_b_pad;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sampled pad levels towards software, spi core and oscillator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_seen           <= '0;
      b_seen           <= '0;
      spi_from_pin     <= '0;
      crystal_in_level <= 1'b0;
    end else begin
      a_seen           <= port_a_in;
      b_seen           <= port_b_in;
      // the spi only hears lines it is not driving
      spi_from_pin.mosi <= ~spi_drive.mosi & port_a_in[0];
      spi_from_pin.miso <= ~spi_drive.miso & port_a_in[1];
      spi_from_pin.sclk <= ~spi_drive.sclk & port_a_in[2];
      crystal_in_level  <= xin_owned & port_b_in[1];
    end
  end

endmodule

`default_nettype wire
